// file: src/cca_timebase.sv
// Local design decision: the APB interface to the registers.
`default_nettype none
// Function
// - Two-bit select picks pclk/6, pclk/2, Timer 0 overflow or external count pin.
// - One 16-bit counter is the common time base for five modules.
// - Modules 0..3 do edge capture, software timer, high-speed output or PWM; module 4 has no pin, so only its software timer acts.
// - Capture, timer and output modes may raise a request when they act.
// - All five module requests and overflow share one interrupt line.
// - Count pin and module pins 0..3 are released to port I/O when unused.
// - Mode bit 6 enables the watchdog function of module 4.
// - Mode bit 7 stops the time base while the processor idles.
// - Mode bit 0 lets the overflow flag raise an interrupt.
// - Mode bits 5..3 are reserved; software never writes ones there.
// - Overflow flag is set on every roll-over and cleared only by software.
module cca_timebase (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_idle,
	input wire logic t0_ovf,
	input wire logic ext_count_input,
	input wire logic [3:0] module_pin_i,
	output logic [3:0] module_pin_o,
	output logic [3:0] module_pin_oe_n,
	output logic [3:0] module_pin_claim,
	output logic eci_claim,
	output logic irq,
	output logic wdog_reset
);
	// Whole block state
	typedef struct packed {
		logic [7:0] mode_r;
		logic run_r;
		logic ovf_flag_r;
		logic [4:0] mod_flag_r;
		cca_pkg::cca_mod_cfg_t [4:0] mcfg_r;
		logic [15:0] count_r;
		logic [2:0] div6_r;
		logic div2_r;
		logic [2:0] eci_sync_r;
		logic [5:0] irq_stat_r;
		logic [5:0] irq_mask_r;
		logic [31:0] rdata_r;
		logic ready_r;
		logic slverr_r;
		logic irq_r;
		logic wdog_r;
		logic eci_claim_r;
	} cca_top_st_t;

	cca_top_st_t st_r;
	cca_top_st_t st_nxt;
	logic [9:0] idx;
	logic setup;
	logic wr_done;
	logic div6_pulse;
	logic div2_pulse;
	logic eci_fall;
	logic src_pulse;
	logic tick;
	logic ovf_set;
	logic cnt_wr;
	logic mapped;
	logic [31:0] rd_mux;
	logic [5:0] irq_gate;
	logic [4:0] val_wr_lo;
	logic [4:0] val_wr_hi;
	logic [4:0] mod_evt;
	logic [4:0] mod_hit;
	logic [4:0] pin_in;
	logic [4:0] pin_o;
	logic [4:0] pin_oe_n;
	logic [4:0] pin_claim;
	logic [15:0] mod_val [5];

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wr_done = psel && penable && st_r.ready_r && pwrite;
	// Module 4 has no pin; its input idles high
	assign pin_in = {1'b1, module_pin_i};

	// Five compare/capture modules on the common count
	for (genvar g = 0; g < cca_pkg::NMOD; g++) begin : g_mod
		cca_module u_mod (
			.pclk(pclk),
			.presetn(presetn),
			.tick(tick),
			.count(st_r.count_r),
			.cfg(st_r.mcfg_r[g]),
			.wr_lo(val_wr_lo[g]),
			.wr_hi(val_wr_hi[g]),
			.wdata(pwdata[7:0]),
			.pin_i(pin_in[g]),
			.value(mod_val[g]),
			.evt(mod_evt[g]),
			.hit(mod_hit[g]),
			.pin_o(pin_o[g]),
			.pin_oe_n(pin_oe_n[g]),
			.claim(pin_claim[g])
		);
	end

	// Count source, gating and counter
	always_comb begin
		st_nxt = st_r;
		div6_pulse = (st_r.div6_r == cca_pkg::DIV6_LAST);
		st_nxt.div6_r = div6_pulse ? 3'h0 : 3'(st_r.div6_r + 3'h1);
		div2_pulse = st_r.div2_r;
		st_nxt.div2_r = ~st_r.div2_r;
		// Count pin passes three flops; a falling edge is taken when stage 2 is low and stage 3 still high
		st_nxt.eci_sync_r = {st_r.eci_sync_r[1:0], ext_count_input};
		eci_fall = !st_r.eci_sync_r[1] && st_r.eci_sync_r[2];
		unique case (st_r.mode_r[cca_pkg::COUNT_SOURCE_SEL_HI:cca_pkg::COUNT_SOURCE_SEL_LO])
			cca_pkg::SRC_DIV6: src_pulse = div6_pulse;
			cca_pkg::SRC_DIV2: src_pulse = div2_pulse;
			cca_pkg::SRC_T0OVF: src_pulse = t0_ovf;
			cca_pkg::SRC_EXT: src_pulse = eci_fall;
		endcase
		// Idle gating only holds the counter; dividers keep running so the rate is steady
		tick = src_pulse && st_r.run_r
			&& !(cpu_idle && st_r.mode_r[cca_pkg::IDLE_GATE_BIT]);
		ovf_set = tick && (st_r.count_r == cca_pkg::CNT_MAX);
		cnt_wr = wr_done && ((idx == cca_pkg::IDX_CNT_LO) || (idx == cca_pkg::IDX_CNT_HI));
		// Wraps naturally from all ones to zero
		if (tick) begin
			st_nxt.count_r = 16'(st_r.count_r + 16'h0001);
		end
		if (wr_done && idx == cca_pkg::IDX_CNT_LO) begin
			st_nxt.count_r[7:0] = pwdata[7:0];
		end
		if (wr_done && idx == cca_pkg::IDX_CNT_HI) begin
			st_nxt.count_r[15:8] = pwdata[7:0];
		end

		// Read mux; reserved mode bits read as zero
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		val_wr_lo = 5'h00;
		val_wr_hi = 5'h00;
		if (idx == cca_pkg::IDX_MODE) begin
			rd_mux[7:0] = st_r.mode_r & cca_pkg::MODE_WMASK;
		end else if (idx == cca_pkg::IDX_CTRL) begin
			rd_mux[7:0] = {st_r.ovf_flag_r, st_r.run_r, 1'b0, st_r.mod_flag_r};
		end else if (idx == cca_pkg::IDX_CNT_LO) begin
			rd_mux[7:0] = st_r.count_r[7:0];
		end else if (idx == cca_pkg::IDX_CNT_HI) begin
			rd_mux[7:0] = st_r.count_r[15:8];
		end else if (idx == cca_pkg::IDX_IRQ_STAT) begin
			rd_mux[5:0] = st_r.irq_stat_r;
		end else if (idx == cca_pkg::IDX_IRQ_MASK) begin
			rd_mux[5:0] = st_r.irq_mask_r;
		end else begin
			mapped = 1'b0;
		end
		for (int i = 0; i < cca_pkg::NMOD; i++) begin
			if (idx == 10'(cca_pkg::IDX_MMODE0 + 10'(i))) begin
				rd_mux[7:0] = st_r.mcfg_r[i] & 8'h7f;
				mapped = 1'b1;
			end
			if (idx == 10'(cca_pkg::IDX_VAL0_LO + 10'(2 * i))) begin
				rd_mux[7:0] = mod_val[i][7:0];
				val_wr_lo[i] = wr_done;
				mapped = 1'b1;
			end
			if (idx == 10'(cca_pkg::IDX_VAL0_LO + 10'(2 * i + 1))) begin
				rd_mux[7:0] = mod_val[i][15:8];
				val_wr_hi[i] = wr_done;
				mapped = 1'b1;
			end
		end

		// APB: answer is ready in the first access cycle, no wait states
		st_nxt.ready_r = setup;
		if (setup) begin
			st_nxt.rdata_r = mapped ? rd_mux : 32'h0000_0000;
			st_nxt.slverr_r = !mapped;
		end

		// Register writes; reserved mode bits are dropped
		if (wr_done && idx == cca_pkg::IDX_MODE) begin
			st_nxt.mode_r = pwdata[7:0] & cca_pkg::MODE_WMASK;
		end
		if (wr_done && idx == cca_pkg::IDX_CTRL) begin
			st_nxt.run_r = pwdata[cca_pkg::RUN_BIT];
			st_nxt.ovf_flag_r = pwdata[cca_pkg::OVF_FLAG_BIT];
			st_nxt.mod_flag_r = pwdata[4:0];
		end
		for (int i = 0; i < cca_pkg::NMOD; i++) begin
			if (wr_done && idx == 10'(cca_pkg::IDX_MMODE0 + 10'(i))) begin
				st_nxt.mcfg_r[i] = pwdata[7:0] & 8'h7f;
			end
		end
		if (wr_done && idx == cca_pkg::IDX_IRQ_MASK) begin
			st_nxt.irq_mask_r = pwdata[5:0];
		end

		// Hardware set wins over a software clear in the same cycle
		if (ovf_set) begin
			st_nxt.ovf_flag_r = 1'b1;
		end
		st_nxt.mod_flag_r = st_nxt.mod_flag_r | mod_evt;

		// Sticky status, write one to clear, set wins
		st_nxt.irq_stat_r = st_r.irq_stat_r;
		if (wr_done && idx == cca_pkg::IDX_IRQ_STAT) begin
			st_nxt.irq_stat_r = st_r.irq_stat_r & ~pwdata[5:0];
		end
		st_nxt.irq_stat_r = st_nxt.irq_stat_r | {ovf_set, mod_evt};

		// Per-source enables: overflow by mode bit 0, modules by their own enable bit
		irq_gate[cca_pkg::IRQ_OVF_BIT] = st_r.mode_r[cca_pkg::OVERFLOW_IRQ_ENABLE];
		for (int i = 0; i < cca_pkg::NMOD; i++) begin
			irq_gate[i] = st_r.mcfg_r[i].eccf;
		end
		// One shared line for every source
		st_nxt.irq_r = |(st_nxt.irq_stat_r & st_r.irq_mask_r & irq_gate);

		// Watchdog reset pulse on a module 4 match only when enabled
		st_nxt.wdog_r = mod_hit[4] && st_r.mode_r[cca_pkg::WDOG_ENABLE_BIT];
		// Count pin belongs to the array only while it is the selected source
		st_nxt.eci_claim_r = (st_r.mode_r[cca_pkg::COUNT_SOURCE_SEL_HI:cca_pkg::COUNT_SOURCE_SEL_LO]
			== cca_pkg::SRC_EXT);
	end

	// Single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{mode_r: cca_pkg::MODE_RST, run_r: 1'b0, ovf_flag_r: 1'b0, mod_flag_r: 5'h00,
				mcfg_r: '0, count_r: cca_pkg::CNT_RST, div6_r: 3'h0, div2_r: 1'b0,
				eci_sync_r: cca_pkg::SYNC_RST, irq_stat_r: 6'h00, irq_mask_r: 6'h00,
				rdata_r: 32'h0000_0000, ready_r: 1'b0, slverr_r: 1'b0, irq_r: 1'b0,
				wdog_r: 1'b0, eci_claim_r: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata = st_r.rdata_r;
	assign pready = st_r.ready_r;
	assign pslverr = st_r.slverr_r;
	assign irq = st_r.irq_r;
	assign wdog_reset = st_r.wdog_r;
	assign eci_claim = st_r.eci_claim_r;
	assign module_pin_o = pin_o[3:0];
	assign module_pin_oe_n = pin_oe_n[3:0];
	assign module_pin_claim = pin_claim[3:0];

	div6_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		div6_pulse |=> !div6_pulse [*5] ##1 div6_pulse)
		else $error("divide-by-six enable has wrong period");
	div2_source_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r.mode_r[2:1] == cca_pkg::SRC_DIV2 && st_r.run_r && !cpu_idle) |-> (tick == st_r.div2_r))
		else $error("divide-by-two source not followed");
	count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !cnt_wr) |=> (st_r.count_r == 16'($past(st_r.count_r) + 16'h0001)))
		else $error("counter did not step by one");
	count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!tick && !cnt_wr) |=> $stable(st_r.count_r))
		else $error("counter moved without a source pulse");
	overflow_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_set && !cnt_wr) |=> (st_r.count_r == 16'h0000) && st_r.ovf_flag_r && st_r.irq_stat_r[5])
		else $error("roll-over did not wrap and flag");
	overflow_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r.ovf_flag_r && !(wr_done && idx == cca_pkg::IDX_CTRL)) |=> st_r.ovf_flag_r)
		else $error("overflow flag cleared without software");
	idle_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_idle && st_r.mode_r[7]) |-> !tick)
		else $error("time base ran while idle gated");
	stopped_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!st_r.run_r && !cnt_wr) [*2] |-> $stable(st_r.count_r))
		else $error("time base ran with run bit clear");
	ovf_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_nxt.irq_stat_r == 6'h20 && !st_r.mode_r[0]) |=> !irq)
		else $error("overflow raised interrupt while disabled");
	shared_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_set && st_r.mode_r[0] && st_r.irq_mask_r[5]) |=> irq)
		else $error("overflow did not reach shared interrupt");
	module_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mod_evt != 5'h00) |=> ((st_r.mod_flag_r & $past(mod_evt)) == $past(mod_evt)))
		else $error("module event did not set its flag");
	wdog_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mod_hit[4] && !st_r.mode_r[6]) |=> !wdog_reset)
		else $error("watchdog fired while disabled");
	reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && idx == cca_pkg::IDX_MODE) |=> (prdata[5:3] == 3'h0) && pready)
		else $error("reserved mode bits not zero");
	eci_claim_a: assert property (@(posedge pclk) disable iff (!presetn)
		($past(st_r.mode_r[2:1]) == cca_pkg::SRC_EXT) |-> eci_claim)
		else $error("count pin not claimed when selected");
endmodule : cca_timebase
`default_nettype wire

// file: src/cca_pkg.sv
`default_nettype none
// Shared constants and carriers for the counter array time base
package cca_pkg;
	// APB address decode: register index is paddr[11:2]
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL = 10'h0d8;      // counter_control_reg
	localparam logic [9:0] IDX_MODE = 10'h0d9;      // counter_mode_control
	localparam logic [9:0] IDX_MMODE0 = 10'h0da;    // Module modes 0..4 at 0da..0de
	localparam logic [9:0] IDX_CNT_LO = 10'h0e0;
	localparam logic [9:0] IDX_CNT_HI = 10'h0e1;
	localparam logic [9:0] IDX_VAL0_LO = 10'h0e2;   // Module n value: lo at 0e2+2n, hi at 0e3+2n
	localparam logic [9:0] IDX_IRQ_STAT = 10'h0ec;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h0ed;
	localparam int NMOD = 5;
	localparam int NPIN = 4;
	// counter_mode_control field positions
	localparam int IDLE_GATE_BIT = 7;
	localparam int WDOG_ENABLE_BIT = 6;
	localparam int COUNT_SOURCE_SEL_HI = 2;
	localparam int COUNT_SOURCE_SEL_LO = 1;
	localparam int OVERFLOW_IRQ_ENABLE = 0;
	localparam logic [7:0] MODE_WMASK = 8'hc7;      // Bits 5..3 reserved, never stored
	// counter_control_reg field positions
	localparam int OVF_FLAG_BIT = 7;
	localparam int RUN_BIT = 6;
	// Interrupt status layout: bits 4..0 modules, bit 5 overflow
	localparam int IRQ_OVF_BIT = 5;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [2:0] SYNC_RST = 3'h7;
	// Count source selections
	localparam logic [1:0] SRC_DIV6 = 2'h0;
	localparam logic [1:0] SRC_DIV2 = 2'h1;
	localparam logic [1:0] SRC_T0OVF = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	// Divider timing: peripheral clock is pclk
	localparam int DIV6_RATIO = 6;
	localparam logic [2:0] DIV6_LAST = 3'(DIV6_RATIO - 1);
	localparam logic [15:0] CNT_MAX = 16'hffff;

	// Per-module mode byte, bit 7 reserved
	typedef struct packed {
		logic rsv;
		logic ecom;
		logic capp;
		logic capn;
		logic mat;
		logic tog;
		logic pwm;
		logic eccf;
	} cca_mod_cfg_t;

	// State of one compare/capture module
	typedef struct packed {
		logic [15:0] value_r;
		logic [2:0] sync_r;
		logic evt_r;
		logic hit_r;
		logic pin_o_r;
		logic pin_oe_n_r;
		logic claim_r;
	} cca_mod_st_t;
endpackage : cca_pkg
`default_nettype wire

// file: src/cca_module.sv
`default_nettype none
// One compare/capture module driven by the shared time base
module cca_module (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic [15:0] count,
	input wire cca_pkg::cca_mod_cfg_t cfg,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	input wire logic pin_i,
	output logic [15:0] value,
	output logic evt,
	output logic hit,
	output logic pin_o,
	output logic pin_oe_n,
	output logic claim
);
	cca_pkg::cca_mod_st_t st_r;
	cca_pkg::cca_mod_st_t st_nxt;
	logic rise;
	logic fall;
	logic cap;
	logic match;

	// Edges use the second and third synchroniser stages only
	always_comb begin
		st_nxt = st_r;
		st_nxt.sync_r = {st_r.sync_r[1:0], pin_i};
		rise = st_r.sync_r[1] && !st_r.sync_r[2];
		fall = !st_r.sync_r[1] && st_r.sync_r[2];
		cap = (cfg.capp && rise) || (cfg.capn && fall);
		match = cfg.ecom && tick && (count == st_r.value_r);
		st_nxt.evt_r = 1'b0;
		st_nxt.hit_r = 1'b0;
		if (wr_lo) begin
			st_nxt.value_r[7:0] = wdata;
		end
		if (wr_hi) begin
			st_nxt.value_r[15:8] = wdata;
		end
		// Capture wins over a software write in the same cycle
		if (cap) begin
			st_nxt.value_r = count;
			st_nxt.evt_r = 1'b1;
		end
		// Software timer and high-speed output
		if (match && !cfg.pwm) begin
			st_nxt.hit_r = 1'b1;
			if (cfg.mat) begin
				st_nxt.evt_r = 1'b1;
			end
			if (cfg.tog) begin
				st_nxt.pin_o_r = ~st_r.pin_o_r;
			end
		end
		// 8-bit PWM: high once the low count byte reaches the duty byte
		if (cfg.ecom && cfg.pwm) begin
			st_nxt.pin_o_r = (count[7:0] >= st_r.value_r[7:0]);
		end
		// Pin stays ordinary port I/O unless a mode needs it
		st_nxt.pin_oe_n_r = !(cfg.tog || cfg.pwm);
		st_nxt.claim_r = cfg.capp || cfg.capn || cfg.tog || cfg.pwm;
	end

	// Pin idles high so a released line reads as a pulled-up port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{value_r: 16'h0000, sync_r: cca_pkg::SYNC_RST, evt_r: 1'b0, hit_r: 1'b0,
				pin_o_r: 1'b1, pin_oe_n_r: 1'b1, claim_r: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.value_r;
	assign evt = st_r.evt_r;
	assign hit = st_r.hit_r;
	assign pin_o = st_r.pin_o_r;
	assign pin_oe_n = st_r.pin_oe_n_r;
	assign claim = st_r.claim_r;

	capture_value_a: assert property (@(posedge pclk) disable iff (!presetn)
		cap |=> (st_r.value_r == $past(count)) && st_r.evt_r)
		else $error("capture did not latch the count");
	toggle_on_match_a: assert property (@(posedge pclk) disable iff (!presetn)
		(match && cfg.tog && !cfg.pwm) |=> (st_r.pin_o_r != $past(st_r.pin_o_r)))
		else $error("pin did not toggle on match");
endmodule : cca_module
`default_nettype wire

// file: test/cca_pin_model.sv
`default_nettype none
// Board side of the array pins: count pin and module pins, all with pull-ups
module cca_pin_model (
	input wire logic pclk,
	input wire logic [3:0] module_pin_o,
	input wire logic [3:0] module_pin_oe_n,
	output logic ext_count_input,
	output logic [3:0] module_pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] drive_r = 4'hf;

	// Pull-up keeps the count pin high between pulses
	initial ext_count_input = 1'h1;

	// Wire level: the array wins while its enable is low, otherwise the board drive or pull-up
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			module_pin_i[k] = module_pin_oe_n[k] ? drive_r[k] : module_pin_o[k];
		end
	end

	// Falling edges on the count pin, held long enough for a three-flop synchroniser
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			ext_count_input <= 1'h0;
			repeat (4) @(posedge pclk);
			ext_count_input <= 1'h1;
			repeat (3) @(posedge pclk);
		end
	endtask : ext_pulses

	// Board drives one module pin; released pins fall back to the pull-up level
	task automatic set_pin(input int k, input logic v);
		@(posedge pclk);
		drive_r[k] <= v;
	endtask : set_pin
endmodule : cca_pin_model
`default_nettype wire

// file: test/counter_array_timebase_control_test.sv
`default_nettype none
// Self-checking bench for the counter array time base, its registers and pins
module counter_array_timebase_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [9:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
		logic err;
	} cca_row_t;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic cpu_idle = 1'h0;
	logic t0_ovf = 1'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ext_count_input, eci_claim, irq, wdog_reset;
	logic [3:0] module_pin_i, module_pin_o, module_pin_oe_n, module_pin_claim;
	int fails = 0;
	int n_compared = 0;
	int wd_n = 0;
	logic [31:0] d;
	logic e;
	// Plain register rows: written value beside the read-back and error it should give
	cca_row_t rows [7] = '{'{10'h0da, 8'h7f, 8'h7f, 1'h0}, '{10'h0e0, 8'ha5, 8'ha5, 1'h0},
		'{10'h0e1, 8'h5a, 8'h5a, 1'h0}, '{10'h0e2, 8'h3c, 8'h3c, 1'h0}, '{10'h0ed, 8'h3f, 8'h3f, 1'h0},
		'{10'h0df, 8'h11, 8'h00, 1'h1}, '{10'h0d9, 8'hc7, 8'hc7, 1'h0}};

	cca_timebase u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_idle(cpu_idle), .t0_ovf(t0_ovf), .ext_count_input(ext_count_input), .module_pin_i(module_pin_i),
		.module_pin_o(module_pin_o), .module_pin_oe_n(module_pin_oe_n), .module_pin_claim(module_pin_claim),
		.eci_claim(eci_claim), .irq(irq), .wdog_reset(wdog_reset));
	cca_pin_model u_pins (.pclk(pclk), .module_pin_o(module_pin_o), .module_pin_oe_n(module_pin_oe_n),
		.ext_count_input(ext_count_input), .module_pin_i(module_pin_i));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Watchdog pulses are single cycles, so they are counted rather than looked at
	always @(posedge pclk) begin
		if (wdog_reset === 1'h1) begin
			wd_n <= wd_n + 1;
		end
	end

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen high at a falling edge
	task automatic apb(input logic wr_en, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr_en;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'h1;
		// Look between edges, where the answer is settled; the request holds to the next rising edge
		@(negedge pclk);
		while (pready !== 1'h1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 40) begin
			fails++;
			$display("unexpected stall at %0t: pready %h expected 1", $time, pready);
		end
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		logic err;
		apb(1'h1, idx, wd, rd, err);
	endtask : wr

	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'h0, idx, 8'h00, rd, err);
		chk(rd, {24'h0, exp});
	endtask : rdc

	// Reads spaced exactly 60 cycles apart, so divider phase cannot change the difference
	task automatic rate(input logic [7:0] mode, input logic idle, input logic [7:0] exp);
		logic [31:0] a;
		logic [31:0] b;
		logic err;
		wr(cca_pkg::IDX_MODE, mode);
		cpu_idle <= idle;
		apb(1'h0, cca_pkg::IDX_CNT_LO, 8'h00, a, err);
		repeat (57) @(posedge pclk);
		apb(1'h0, cca_pkg::IDX_CNT_LO, 8'h00, b, err);
		chk({24'h0, 8'(b[7:0] - a[7:0])}, {24'h0, exp});
	endtask : rate

	task automatic t0_pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			t0_ovf <= 1'h1;
			@(posedge pclk);
			t0_ovf <= 1'h0;
			repeat (2) @(posedge pclk);
		end
		repeat (4) @(posedge pclk);
	endtask : t0_pulses

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		fails++;
		$display("unexpected timeout at %0t: got %h expected %h", $time, 1'h1, 1'h0);
		test_done();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i]) begin
			apb(1'h1, rows[i].idx, rows[i].wd, d, e);
			apb(1'h0, rows[i].idx, 8'h00, d, e);
			chk(d, {24'h0, rows[i].rd});
			chk({31'h0, e}, {31'h0, rows[i].err});
		end
		$display("test register rows done");
		// Mid-run reset: everything back to idle, pins released
		chk({31'h0, eci_claim}, 32'h1);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk({20'h0, module_pin_o, module_pin_oe_n, module_pin_claim}, 32'h00ff0);
		chk({29'h0, eci_claim, irq, wdog_reset}, 32'h0);
		presetn <= 1'h1;
		rdc(cca_pkg::IDX_MODE, 8'h00);
		rdc(cca_pkg::IDX_CNT_LO, 8'h00);
		$display("test reset done");
		// Count sources and idle gating
		wr(cca_pkg::IDX_CTRL, 8'h40);
		rate(8'h00, 1'h0, 8'h0a);
		rate(8'h02, 1'h0, 8'h1e);
		rate(8'h82, 1'h1, 8'h00);
		rate(8'h02, 1'h1, 8'h1e);
		wr(cca_pkg::IDX_MODE, 8'h04);
		wr(cca_pkg::IDX_CNT_LO, 8'h00);
		t0_pulses(7);
		rdc(cca_pkg::IDX_CNT_LO, 8'h07);
		wr(cca_pkg::IDX_MODE, 8'h06);
		wr(cca_pkg::IDX_CNT_LO, 8'h00);
		u_pins.ext_pulses(5);
		repeat (8) @(posedge pclk);
		rdc(cca_pkg::IDX_CNT_LO, 8'h05);
		chk({31'h0, eci_claim}, 32'h1);
		$display("test count sources done");
		// Roll-over from all ones, sticky flag, interrupt enable
		wr(cca_pkg::IDX_IRQ_MASK, 8'h20);
		wr(cca_pkg::IDX_MODE, 8'h05);
		wr(cca_pkg::IDX_CNT_LO, 8'hfe);
		wr(cca_pkg::IDX_CNT_HI, 8'hff);
		t0_pulses(2);
		rdc(cca_pkg::IDX_CNT_HI, 8'h00);
		rdc(cca_pkg::IDX_CNT_LO, 8'h00);
		rdc(cca_pkg::IDX_CTRL, 8'hc0);
		chk({31'h0, irq}, 32'h1);
		wr(cca_pkg::IDX_MODE, 8'h04);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(cca_pkg::IDX_CTRL, 8'hc0);
		wr(cca_pkg::IDX_CTRL, 8'h00);
		wr(cca_pkg::IDX_IRQ_STAT, 8'h3f);
		rdc(cca_pkg::IDX_CTRL, 8'h00);
		$display("test overflow done");
		// Timer, toggle output and watchdog modules sharing one match value, PWM module with duty 03
		wr(cca_pkg::IDX_IRQ_MASK, 8'h01);
		wr(cca_pkg::IDX_MODE, 8'h44);
		wr(10'h0da, 8'h49);
		wr(10'h0e2, 8'h05);
		wr(10'h0db, 8'h4c);
		wr(10'h0e4, 8'h05);
		wr(10'h0dd, 8'h42);
		wr(10'h0e8, 8'h03);
		wr(10'h0de, 8'h48);
		wr(10'h0ea, 8'h05);
		wr(cca_pkg::IDX_CTRL, 8'h40);
		t0_pulses(6);
		chk(32'(wd_n), 32'h1);
		chk({28'h0, module_pin_o[1], module_pin_oe_n[1], module_pin_o[3], module_pin_oe_n[3]}, 32'h2);
		chk({31'h0, irq}, 32'h1);
		rdc(cca_pkg::IDX_CTRL, 8'h53);
		wr(cca_pkg::IDX_MODE, 8'h04);
		wr(cca_pkg::IDX_CNT_LO, 8'h04);
		t0_pulses(2);
		chk(32'(wd_n), 32'h1);
		chk({31'h0, module_pin_o[1]}, 32'h1);
		// Rising-edge capture of the running count on module 2
		wr(10'h0dc, 8'h21);
		u_pins.set_pin(2, 1'h0);
		repeat (6) @(posedge pclk);
		u_pins.set_pin(2, 1'h1);
		repeat (8) @(posedge pclk);
		rdc(10'h0e6, 8'h06);
		rdc(cca_pkg::IDX_CTRL, 8'h57);
		chk({28'h0, module_pin_claim}, 32'he);
		$display("test modules done");
		test_done();
	end
endmodule : counter_array_timebase_control_test
`default_nettype wire
